// ===== core/sbrl_pkg.sv
// Package for the shunt/bus result and alert-limit register bank
package sbrl_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] SBRL_ADDR_CH1_SHUNT  = 8'h01;
	localparam logic [7:0] SBRL_ADDR_CH1_BUS    = 8'h02;
	localparam logic [7:0] SBRL_ADDR_CH2_SHUNT  = 8'h03;
	localparam logic [7:0] SBRL_ADDR_CH2_BUS    = 8'h04;
	localparam logic [7:0] SBRL_ADDR_CH3_SHUNT  = 8'h05;
	localparam logic [7:0] SBRL_ADDR_CH3_BUS    = 8'h06;
	localparam logic [7:0] SBRL_ADDR_CH1_FAST   = 8'h07;
	localparam logic [7:0] SBRL_ADDR_CH1_SLOW   = 8'h08;
	localparam logic [7:0] SBRL_ADDR_CH2_FAST   = 8'h09;

	// ==========================================================
	// Field layout and reset values
	localparam int          SBRL_SIGN_POS       = 15;
	localparam int          SBRL_DATA_LSB_POS   = 3;
	localparam int          SBRL_CODE_W         = 13;
	localparam int          SBRL_NUM_CH         = 3;
	localparam int          SBRL_NUM_RES        = 6;
	localparam int          SBRL_NUM_LIM        = 3;
	localparam logic [15:0] SBRL_RESULT_RESET   = 16'h0000;
	localparam logic [15:0] SBRL_LIMIT_RESET    = 16'h7FF8;
	localparam logic [15:0] SBRL_UNMAPPED_READ  = 16'h0000;
	localparam logic [2:0]  SBRL_RESERVED_ZERO  = 3'h0;

	// Indices into the limit array
	localparam int          SBRL_LIM_CH1_FAST   = 0;
	localparam int          SBRL_LIM_CH1_SLOW   = 1;
	localparam int          SBRL_LIM_CH2_FAST   = 2;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [2:0]        valid;
		logic [2:0][12:0]  code;
	} sbrl_sample_t;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [7:0]        addr;
		logic [15:0]       wdata;
	} sbrl_access_t;

endpackage

// ===== core/sbrl_regs.sv
// Result and alert-limit register bank of a three-channel shunt/bus monitor
`timescale 1ns/1ps
`default_nettype none

module sbrl_regs
	import sbrl_pkg::*;
(
	input  wire logic          SYS_CLK,
	input  wire logic          SRST,
	input  wire logic          CLK_EN,
	input  wire sbrl_access_t  REG_ACCESS,
	input  wire sbrl_sample_t  SHUNT_RAW,
	input  wire sbrl_sample_t  SHUNT_AVG,
	input  wire sbrl_sample_t  BUS_SAMPLE,
	output logic [15:0]        REG_RDATA,
	output logic               REG_RVALID,
	output logic [1:0]         FAST_ALERT,
	output logic               SLOW_ALERT
);

	// ==========================================================
	// Helpers
	function automatic logic [15:0] align_code(input logic [12:0] code);
		align_code = {code, SBRL_RESERVED_ZERO};
	endfunction

	// Only the 13-bit value takes part; reserved limit bits are ignored
	function automatic logic above_limit(input logic [15:0] value, input logic [15:0] limit);
		above_limit = $signed(value[SBRL_SIGN_POS:SBRL_DATA_LSB_POS])
			> $signed(limit[SBRL_SIGN_POS:SBRL_DATA_LSB_POS]);
	endfunction

	function automatic logic is_result_addr(input logic [7:0] addr);
		is_result_addr = (addr >= SBRL_ADDR_CH1_SHUNT) && (addr <= SBRL_ADDR_CH3_BUS);
	endfunction

	function automatic logic is_limit_addr(input logic [7:0] addr);
		is_limit_addr = (addr >= SBRL_ADDR_CH1_FAST) && (addr <= SBRL_ADDR_CH2_FAST);
	endfunction

	// ==========================================================
	// Storage
	// Even index = shunt, odd index = bus, ordered by address
	logic [15:0] res_reg [SBRL_NUM_RES];
	logic [15:0] lim_reg [SBRL_NUM_LIM];
	logic [15:0] rdata_next;
	logic [2:0]  res_idx;
	logic [1:0]  lim_idx;

	assign res_idx = 3'(REG_ACCESS.addr - SBRL_ADDR_CH1_SHUNT);
	assign lim_idx = 2'(REG_ACCESS.addr - SBRL_ADDR_CH1_FAST);

	// ==========================================================
	// Result registers
	// Whole word loads in one edge, so a read never mixes conversions
	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
		begin
			for (int i = 0; i < SBRL_NUM_RES; i++)
			begin
				res_reg[i] <= SBRL_RESULT_RESET;
			end
		end
		else if (CLK_EN)
		begin
			for (int c = 0; c < SBRL_NUM_CH; c++)
			begin
				if (SHUNT_AVG.valid[c])
				begin
					res_reg[2*c] <= align_code(SHUNT_AVG.code[c]);
				end
				if (BUS_SAMPLE.valid[c])
				begin
					res_reg[2*c+1] <= align_code(BUS_SAMPLE.code[c]);
				end
			end
		end
	end

	// ==========================================================
	// Limit registers
	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
		begin
			for (int i = 0; i < SBRL_NUM_LIM; i++)
			begin
				lim_reg[i] <= SBRL_LIMIT_RESET;
			end
		end
		else if (CLK_EN && REG_ACCESS.wr && is_limit_addr(REG_ACCESS.addr))
		begin
			lim_reg[lim_idx] <= REG_ACCESS.wdata;
		end
	end

	// ==========================================================
	// Read port
	always_comb
	begin
		rdata_next = SBRL_UNMAPPED_READ;
		if (is_result_addr(REG_ACCESS.addr))
		begin
			rdata_next = res_reg[res_idx];
		end
		else if (is_limit_addr(REG_ACCESS.addr))
		begin
			rdata_next = lim_reg[lim_idx];
		end
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
		begin
			REG_RDATA  <= SBRL_UNMAPPED_READ;
			REG_RVALID <= 1'b0;
		end
		else if (CLK_EN)
		begin
			REG_RVALID <= REG_ACCESS.rd;
			if (REG_ACCESS.rd)
			begin
				REG_RDATA <= rdata_next;
			end
		end
	end

	// ==========================================================
	// Alert comparisons
	// Fast alerts follow single conversions so short spikes are not averaged away
	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
		begin
			FAST_ALERT <= 2'h0;
		end
		else if (CLK_EN)
		begin
			if (SHUNT_RAW.valid[0])
			begin
				FAST_ALERT[0] <= above_limit(align_code(SHUNT_RAW.code[0]),
					lim_reg[SBRL_LIM_CH1_FAST]);
			end
			if (SHUNT_RAW.valid[1])
			begin
				FAST_ALERT[1] <= above_limit(align_code(SHUNT_RAW.code[1]),
					lim_reg[SBRL_LIM_CH2_FAST]);
			end
		end
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
		begin
			SLOW_ALERT <= 1'b0;
		end
		else if (CLK_EN && SHUNT_AVG.valid[0])
		begin
			SLOW_ALERT <= above_limit(align_code(SHUNT_AVG.code[0]),
				lim_reg[SBRL_LIM_CH1_SLOW]);
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SRST);

	AST_RESULT_LOW_ZERO: assert property (
		(CLK_EN && REG_ACCESS.rd && is_result_addr(REG_ACCESS.addr))
		|=> (REG_RVALID && REG_RDATA[2:0] == 3'h0))
		else $error("result read shows nonzero reserved bits");

	AST_SHUNT_AVG_LOAD: assert property (
		(CLK_EN && SHUNT_AVG.valid[2])
		|=> (res_reg[4] == {$past(SHUNT_AVG.code[2]), 3'h0}))
		else $error("ch3 shunt result not loaded from averaged value");

	AST_SIGN_FOLLOWS: assert property (
		(CLK_EN && SHUNT_AVG.valid[0])
		|=> (res_reg[0][15] == $past(SHUNT_AVG.code[0][12])))
		else $error("shunt result sign bit wrong");

	AST_BUS_LOAD: assert property (
		(CLK_EN && BUS_SAMPLE.valid[1])
		|=> (res_reg[3] == {$past(BUS_SAMPLE.code[1]), 3'h0}))
		else $error("ch2 bus result not loaded");

	AST_RESULT_RO: assert property (
		(CLK_EN && REG_ACCESS.wr && REG_ACCESS.addr == SBRL_ADDR_CH3_BUS
			&& !BUS_SAMPLE.valid[2])
		|=> $stable(res_reg[5]))
		else $error("write changed a read-only result");

	AST_CH1_FAST_CMP: assert property (
		(CLK_EN && SHUNT_RAW.valid[0])
		|=> (FAST_ALERT[0] == ($signed($past(SHUNT_RAW.code[0]))
			> $signed($past(lim_reg[0][15:3])))))
		else $error("ch1 fast alert does not match comparison");

	AST_CH1_SLOW_CMP: assert property (
		(CLK_EN && SHUNT_AVG.valid[0])
		|=> (SLOW_ALERT == ($signed($past(SHUNT_AVG.code[0]))
			> $signed($past(lim_reg[1][15:3])))))
		else $error("ch1 slow alert does not match comparison");

	AST_CH2_FAST_CMP: assert property (
		(CLK_EN && SHUNT_RAW.valid[1])
		|=> (FAST_ALERT[1] == ($signed($past(SHUNT_RAW.code[1]))
			> $signed($past(lim_reg[2][15:3])))))
		else $error("ch2 fast alert does not match comparison");

	AST_LIMIT_WRITE_READ: assert property (
		(CLK_EN && REG_ACCESS.wr && REG_ACCESS.addr == SBRL_ADDR_CH2_FAST)
		##1 (CLK_EN && !REG_ACCESS.wr)
		##1 (CLK_EN && REG_ACCESS.rd && !REG_ACCESS.wr
			&& REG_ACCESS.addr == SBRL_ADDR_CH2_FAST)
		|=> (REG_RDATA == $past(REG_ACCESS.wdata, 3)))
		else $error("limit readback differs from written word");

	AST_CH2_BUS_ADDR: assert property (
		(CLK_EN && REG_ACCESS.rd && REG_ACCESS.addr == SBRL_ADDR_CH2_BUS)
		|=> (REG_RDATA == $past(res_reg[3])))
		else $error("04h read not ch2 bus result");

	AST_CH1_SHUNT_ADDR: assert property (
		(CLK_EN && REG_ACCESS.rd && REG_ACCESS.addr == SBRL_ADDR_CH1_SHUNT)
		|=> (REG_RDATA == $past(res_reg[0])))
		else $error("01h read not ch1 shunt result");

	AST_LIMIT_RESET: assert property (
		$past(SRST) |-> (lim_reg[SBRL_LIM_CH1_FAST] == SBRL_LIMIT_RESET
			&& lim_reg[SBRL_LIM_CH1_SLOW] == SBRL_LIMIT_RESET
			&& lim_reg[SBRL_LIM_CH2_FAST] == SBRL_LIMIT_RESET))
		else $error("limit reset value wrong");

	AST_FREEZE: assert property (
		!CLK_EN |=> ($stable(REG_RDATA) && $stable(FAST_ALERT) && $stable(SLOW_ALERT)))
		else $error("state moved with clock enable low");

	AST_RVALID_FOLLOWS: assert property (
		(!SRST && CLK_EN) |=> (REG_RVALID == $past(REG_ACCESS.rd)))
		else $error("read answer strobe does not follow read request");

	AST_UNMAPPED_READ: assert property (
		(CLK_EN && REG_ACCESS.rd && !is_result_addr(REG_ACCESS.addr)
			&& !is_limit_addr(REG_ACCESS.addr))
		|=> (REG_RDATA == SBRL_UNMAPPED_READ))
		else $error("unmapped read returned nonzero data");

	AST_CH1_BUS_ADDR: assert property (
		(CLK_EN && REG_ACCESS.rd && REG_ACCESS.addr == SBRL_ADDR_CH1_BUS)
		|=> (REG_RDATA == $past(res_reg[1])))
		else $error("02h read not ch1 bus result");

	AST_CH2_SHUNT_ADDR: assert property (
		(CLK_EN && REG_ACCESS.rd && REG_ACCESS.addr == SBRL_ADDR_CH2_SHUNT)
		|=> (REG_RDATA == $past(res_reg[2])))
		else $error("03h read not ch2 shunt result");

	AST_CH3_SHUNT_ADDR: assert property (
		(CLK_EN && REG_ACCESS.rd && REG_ACCESS.addr == SBRL_ADDR_CH3_SHUNT)
		|=> (REG_RDATA == $past(res_reg[4])))
		else $error("05h read not ch3 shunt result");

	AST_CH3_BUS_ADDR: assert property (
		(CLK_EN && REG_ACCESS.rd && REG_ACCESS.addr == SBRL_ADDR_CH3_BUS)
		|=> (REG_RDATA == $past(res_reg[5])))
		else $error("06h read not ch3 bus result");

	AST_CH1_FAST_ADDR: assert property (
		(CLK_EN && REG_ACCESS.rd && REG_ACCESS.addr == SBRL_ADDR_CH1_FAST)
		|=> (REG_RDATA == $past(lim_reg[SBRL_LIM_CH1_FAST])))
		else $error("07h read not ch1 fast limit");

	AST_CH1_SLOW_ADDR: assert property (
		(CLK_EN && REG_ACCESS.rd && REG_ACCESS.addr == SBRL_ADDR_CH1_SLOW)
		|=> (REG_RDATA == $past(lim_reg[SBRL_LIM_CH1_SLOW])))
		else $error("08h read not ch1 slow limit");

	AST_CH2_FAST_ADDR: assert property (
		(CLK_EN && REG_ACCESS.rd && REG_ACCESS.addr == SBRL_ADDR_CH2_FAST)
		|=> (REG_RDATA == $past(lim_reg[SBRL_LIM_CH2_FAST])))
		else $error("09h read not ch2 fast limit");

	AST_SLOW_LIMIT_LOAD: assert property (
		(CLK_EN && REG_ACCESS.wr && REG_ACCESS.addr == SBRL_ADDR_CH1_SLOW)
		|=> (lim_reg[SBRL_LIM_CH1_SLOW] == $past(REG_ACCESS.wdata)))
		else $error("ch1 slow limit did not take the written word");

	AST_CH3_BUS_LOAD: assert property (
		(CLK_EN && BUS_SAMPLE.valid[2])
		|=> (res_reg[5] == {$past(BUS_SAMPLE.code[2]), SBRL_RESERVED_ZERO}))
		else $error("ch3 bus result not loaded");

	AST_CH2_SHUNT_LOAD: assert property (
		(CLK_EN && SHUNT_AVG.valid[1])
		|=> (res_reg[2] == {$past(SHUNT_AVG.code[1]), SBRL_RESERVED_ZERO}))
		else $error("ch2 shunt result not loaded");

	// Reset edges excluded: the clear only shows in the following sample
	AST_RAW_KEEPS_RESULT: assert property (
		(!SRST && CLK_EN && SHUNT_RAW.valid[0] && !SHUNT_AVG.valid[0])
		|=> $stable(res_reg[0]))
		else $error("raw conversion reached the ch1 shunt result");

	AST_FAST_HOLD: assert property (
		(!SRST && !(CLK_EN && SHUNT_RAW.valid[0]))
		|=> $stable(FAST_ALERT[0]))
		else $error("ch1 fast alert moved without a raw conversion");

	AST_SLOW_HOLD: assert property (
		(!SRST && !(CLK_EN && SHUNT_AVG.valid[0]))
		|=> $stable(SLOW_ALERT))
		else $error("ch1 slow alert moved without an averaged value");

	AST_RESULT_RESET: assert property (
		$past(SRST) |-> (res_reg[0] == SBRL_RESULT_RESET && res_reg[1] == SBRL_RESULT_RESET
			&& res_reg[2] == SBRL_RESULT_RESET && res_reg[3] == SBRL_RESULT_RESET
			&& res_reg[4] == SBRL_RESULT_RESET && res_reg[5] == SBRL_RESULT_RESET
			&& REG_RDATA == SBRL_UNMAPPED_READ && !REG_RVALID
			&& FAST_ALERT == 2'h0 && !SLOW_ALERT))
		else $error("result or output not cleared by reset");

	COV_FAST_ALERT: cover property (CLK_EN && SHUNT_RAW.valid[0] ##1 FAST_ALERT[0]);
	COV_SLOW_ALERT: cover property (CLK_EN && SHUNT_AVG.valid[0] ##1 SLOW_ALERT);
	COV_LIMIT_WRITE: cover property (CLK_EN && REG_ACCESS.wr && is_limit_addr(REG_ACCESS.addr));
	COV_NEG_RESULT: cover property (CLK_EN && REG_ACCESS.rd ##1 REG_RDATA[15]);
	COV_FROZEN_STROBE: cover property (!CLK_EN && SHUNT_RAW.valid[0]);

endmodule

`default_nettype wire

// ===== sim/sbrl_host.sv
// Register-port host model issuing single-word reads and writes
`timescale 1ns/1ps
`default_nettype none
module sbrl_host
	import sbrl_pkg::*;
(
	input  wire logic          SYS_CLK,
	input  wire logic [15:0]   REG_RDATA,
	input  wire logic          REG_RVALID,
	output var  sbrl_access_t  REG_ACCESS
);
	initial
		REG_ACCESS = '0;

	// Unqualified data lines toggle so stale data never looks valid
	task automatic idle();
		REG_ACCESS.wr    <= 1'b0;
		REG_ACCESS.rd    <= 1'b0;
		REG_ACCESS.wdata <= ~REG_ACCESS.wdata;
	endtask

	task automatic write(input logic [7:0] a, input logic [15:0] d);
		REG_ACCESS <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge SYS_CLK);
		idle();
		@(posedge SYS_CLK);
	endtask

	// Answer is sampled at the edge after the taking edge
	task automatic read(input logic [7:0] a, output logic [15:0] d);
		REG_ACCESS <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~REG_ACCESS.wdata};
		@(posedge SYS_CLK);
		idle();
		@(posedge SYS_CLK);
		d = (REG_RVALID === 1'b1) ? REG_RDATA : 16'hXXXX;
	endtask
endmodule
`default_nettype wire

// ===== sim/sbrl_regs_tb.sv
// Self-checking bench for the result and limit register bank
`timescale 1ns/1ps
`default_nettype none
module sbrl_regs_tb
	import sbrl_pkg::*;
;
	logic          sys_clk;
	logic          srst;
	logic          clk_en;
	sbrl_access_t  acc;
	sbrl_sample_t  smp [3];
	logic [15:0]   rdata;
	logic          rvalid;
	logic [1:0]    fast;
	logic          slow;
	logic [15:0]   got;
	int            fails = 0;
	int            checked = 0;
	int            cycles = 0;
	logic [12:0]   sc [3] = '{13'h1830, 13'h0FFF, 13'h1000};
	logic [12:0]   bc [3] = '{13'h0FFF, 13'h1FFF, 13'h0AAA};
	logic [15:0]   lw [3] = '{16'h000F, 16'hFFF8, 16'h8007};

	sbrl_regs dut (
		.SYS_CLK    (sys_clk),
		.SRST       (srst),
		.CLK_EN     (clk_en),
		.REG_ACCESS (acc),
		.SHUNT_RAW  (smp[0]),
		.SHUNT_AVG  (smp[1]),
		.BUS_SAMPLE (smp[2]),
		.REG_RDATA  (rdata),
		.REG_RVALID (rvalid),
		.FAST_ALERT (fast),
		.SLOW_ALERT (slow)
	);

	sbrl_host host (
		.SYS_CLK    (sys_clk),
		.REG_RDATA  (rdata),
		.REG_RVALID (rvalid),
		.REG_ACCESS (acc)
	);

	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// ==========================================================
	// Shared tasks
	task automatic test_done();
		$display("fails=%0d checked=%0d", fails, checked);
		if (fails == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e)
		begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// Kind 0 raw shunt, 1 averaged shunt, 2 bus
	task automatic pulse(input int k, input int ch, input logic [12:0] c);
		smp[k].valid[ch] <= 1'b1;
		smp[k].code[ch]  <= c;
		@(posedge sys_clk);
		smp[k].valid[ch] <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic step(input int k, input int ch, input logic [12:0] c, input logic [2:0] e);
		pulse(k, ch, c);
		chk({13'h0, fast, slow}, {13'h0, e});
	endtask

	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 1000)
		begin
			fails++;
			test_done();
		end
	end

	// ==========================================================
	// Test sequence
	initial
	begin
		clk_en <= 1'b1;
		srst <= 1'b1;
		smp[0] <= '0;
		smp[1] <= '0;
		smp[2] <= '0;
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		for (int a = 0; a < 11; a++)
		begin
			host.read(8'(a), got);
			chk(got, (a > 6 && a < 10) ? SBRL_LIMIT_RESET : SBRL_RESULT_RESET);
		end
		step(0, 0, 13'h0FFF, 3'h0);
		for (int c = 0; c < 3; c++)
		begin
			pulse(1, c, sc[c]);
			pulse(0, c, 13'h0555);
			pulse(2, c, 13'h0123);
			pulse(2, c, bc[c]);
			host.read(8'(1 + 2 * c), got);
			chk(got, {sc[c], 3'h0});
			host.read(8'(2 + 2 * c), got);
			chk(got, {bc[c], 3'h0});
		end
		for (int i = 1; i < 3; i++)
		begin
			host.write(8'(2 + 2 * i), 16'h1234);
			host.read(8'(2 + 2 * i), got);
			chk(got, {bc[i], 3'h0});
		end
		for (int i = 0; i < 3; i++)
		begin
			host.write(8'(7 + i), lw[i]);
			host.read(8'(7 + i), got);
			chk(got, lw[i]);
		end
		step(0, 0, 13'h0001, 3'h0);
		step(0, 0, 13'h0002, 3'h2);
		step(0, 0, 13'h1FFF, 3'h0);
		step(1, 0, 13'h0000, 3'h1);
		step(1, 0, 13'h1FFE, 3'h0);
		step(0, 1, 13'h1000, 3'h0);
		step(0, 1, 13'h1001, 3'h4);
		// Frozen: both strobes would change state if taken
		clk_en <= 1'b0;
		pulse(0, 0, 13'h0002);
		pulse(1, 0, 13'h0000);
		chk({13'h0, fast, slow}, 16'h0004);
		clk_en <= 1'b1;
		host.read(SBRL_ADDR_CH1_SHUNT, got);
		chk(got, {13'h1FFE, 3'h0});
		srst <= 1'b1;
		@(posedge sys_clk);
		srst <= 1'b0;
		host.read(SBRL_ADDR_CH1_FAST, got);
		chk(got, SBRL_LIMIT_RESET);
		chk({13'h0, fast, slow}, 16'h0000);
		test_done();
	end
endmodule
`default_nettype wire
